// *** core/icc_top.sv ***
/*
 * Input capture channel: edge detection, prescaling, timer capture into a
 * four-entry buffer, capture interrupt pacing and a wake-up pin mode, with
 * a classic wishbone register slave.
 * Assumes the capture pin, timer counts and power state inputs are
 * synchronous to clk_i, and a wishbone master that holds each request
 * until ack.
 */
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`default_nettype none

`include "icc_cfg.svh"

module icc_top
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // register bus
    input  wire icc_pkg::icc_wb_req_s wb_req_i,
    output icc_pkg::icc_wb_rsp_s     wb_rsp_o,
    // capture input and timers
    input  wire logic                cap_pin_i,
    input  wire icc_pkg::icc_word_t  second_timer_count_i,
    input  wire icc_pkg::icc_word_t  third_timer_count_i,
    // power state
    input  wire logic                cpu_idle_i,
    input  wire logic                cpu_sleep_i,
    // events
    output logic                     capture_irq_o,
    output logic                     wake_irq_o
);

    // ======================================================================
    // decoding helpers
    function automatic logic capturing(input logic [2:0] mode);
        capturing = (mode != `ICC_MODE_OFF) && (mode != `ICC_MODE_UNUSED)
                 && (mode != `ICC_MODE_WAKE);
    endfunction

    function automatic logic [15:0] ctrl_word(input icc_pkg::icc_ctrl_s c,
                                              input logic ovf,
                                              input logic bne);
        ctrl_word                                  = `ICC_CTRL_RST;
        ctrl_word[`ICC_SIDL_BIT]                   = c.sidl;
        ctrl_word[`ICC_TMR_BIT]                    = c.tmr;
        ctrl_word[`ICC_ICI_LSB +: 2]               = c.ici;
        ctrl_word[`ICC_OVF_BIT]                    = ovf;
        ctrl_word[`ICC_BNE_BIT]                    = bne;
        ctrl_word[`ICC_MODE_LSB +: 3]              = c.mode;
    endfunction

    // ======================================================================
    // state and buffer wiring
    icc_pkg::icc_state_s    s_q;
    icc_pkg::icc_state_s    s_d;
    logic                   rise;
    logic                   fall;
    logic                   run;
    logic                   cap;
    logic                   pop;
    logic                   bus_req;
    logic                   buf_full;
    logic                   buf_empty;
    logic [`ICC_FIFO_CW-1:0] buf_count;
    logic [`ICC_DATA_W-1:0] buf_head;
    icc_pkg::icc_word_t     cap_value;
    logic [15:0]            wr_word;

    assign rise      = cap_pin_i && !s_q.pin_prev;
    assign fall      = !cap_pin_i && s_q.pin_prev;
    // sleep stops capture outright; idle only when stop-in-idle is set
    assign run       = !cpu_sleep_i && !(cpu_idle_i && s_q.ctrl.sidl);
    assign cap_value = s_q.ctrl.tmr ? second_timer_count_i
                                    : third_timer_count_i;
    // the ack gate stops a held request from being taken a second time
    assign bus_req   = wb_req_i.cyc && wb_req_i.stb && !s_q.ack;

    // leaving the capture modes flushes the buffer, so no stale value survives
    icc_fifo u_fifo
    (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .clear_i     (!capturing(s_q.ctrl.mode)),
        .push_i      (cap),
        .push_data_i (cap_value),
        .pop_i       (pop),
        .head_o      (buf_head),
        .full_o      (buf_full),
        .empty_o     (buf_empty),
        .count_o     (buf_count)
    );

    // ======================================================================
    // next state
    always_comb
    begin
        s_d          = s_q;
        s_d.pin_prev = cap_pin_i;
        s_d.irq      = 1'b0;
        s_d.wake     = 1'b0;
        s_d.ack      = 1'b0;
        cap          = 1'b0;
        pop          = 1'b0;
        wr_word      = ctrl_word(s_q.ctrl, s_q.ovf, !buf_empty);

        // edge selection per mode
        if (run)
        begin
            unique case (s_q.ctrl.mode)
                `ICC_MODE_EVERY: cap = rise || fall;
                `ICC_MODE_FALL:  cap = fall;
                `ICC_MODE_RISE:  cap = rise;
                `ICC_MODE_PRE4:
                begin
                    if (rise)
                    begin
                        cap         = (s_q.pre_cnt == `ICC_PRE4_LAST);
                        s_d.pre_cnt = cap ? 4'h0 : s_q.pre_cnt + 4'h1;
                    end
                end
                `ICC_MODE_PRE16:
                begin
                    if (rise)
                    begin
                        cap         = (s_q.pre_cnt == `ICC_PRE16_LAST);
                        s_d.pre_cnt = s_q.pre_cnt + 4'h1;
                    end
                end
                default:         cap = 1'b0;
            endcase
        end

        // wake pin: only as a rising edge while the core is asleep or idle
        if ((s_q.ctrl.mode == `ICC_MODE_WAKE) && rise && (cpu_sleep_i || cpu_idle_i))
        begin
            s_d.wake = 1'b1;
        end

        // interrupt pacing; both-edge mode ignores the count field
        if (cap)
        begin
            if ((s_q.ctrl.mode == `ICC_MODE_EVERY) || (s_q.ctrl.ici == 2'h0))
            begin
                s_d.irq = 1'b1;
            end
            else if (s_q.irq_cnt == s_q.ctrl.ici)
            begin
                s_d.irq     = 1'b1;
                s_d.irq_cnt = 2'h0;
            end
            else
            begin
                s_d.irq_cnt = s_q.irq_cnt + 2'h1;
            end
        end

        // register slave: answer one cycle after the request is seen
        if (bus_req)
        begin
            s_d.ack  = 1'b1;
            s_d.rdat = 32'h0000_0000;
            if (wb_req_i.adr == `ICC_CTRL_OFS)
            begin
                s_d.rdat = {16'h0000, ctrl_word(s_q.ctrl, s_q.ovf, !buf_empty)};
                if (wb_req_i.we)
                begin
                    if (wb_req_i.sel[0])
                    begin
                        wr_word[7:0] = wb_req_i.dat[7:0];
                    end
                    if (wb_req_i.sel[1])
                    begin
                        wr_word[15:8] = wb_req_i.dat[15:8];
                    end
                    s_d.ctrl.sidl = wr_word[`ICC_SIDL_BIT];
                    s_d.ctrl.tmr  = wr_word[`ICC_TMR_BIT];
                    s_d.ctrl.ici  = wr_word[`ICC_ICI_LSB +: 2];
                    s_d.ctrl.mode = wr_word[`ICC_MODE_LSB +: 3];
                    // a new mode or pacing starts its counts afresh
                    if (s_d.ctrl != s_q.ctrl)
                    begin
                        s_d.pre_cnt = 4'h0;
                        s_d.irq_cnt = 2'h0;
                    end
                end
            end
            else if ((wb_req_i.adr == `ICC_BUF_OFS) && !wb_req_i.we && !buf_empty)
            begin
                s_d.rdat = {16'h0000, buf_head};
                pop      = 1'b1;
            end
        end

        // overflow: cleared by reading the buffer empty, set wins
        if (pop && (buf_count == `ICC_FIFO_CW'(1)) && !cap)
        begin
            s_d.ovf = 1'b0;
        end
        if (cap && buf_full && !pop)
        begin
            s_d.ovf = 1'b1;
        end

        // switched off: counters and flags return to rest
        if (!capturing(s_q.ctrl.mode))
        begin
            s_d.ovf     = 1'b0;
            s_d.pre_cnt = 4'h0;
            s_d.irq_cnt = 2'h0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // outputs
    assign wb_rsp_o.ack = s_q.ack;
    assign wb_rsp_o.dat = s_q.rdat;
    assign capture_irq_o = s_q.irq;
    assign wake_irq_o    = s_q.wake;

    // ======================================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_off_no_capture: assert property (
        (s_q.ctrl.mode == `ICC_MODE_OFF) |-> (!cap ##1 !capture_irq_o))
        else $error("capture while channel off");

    a_both_edges: assert property (
        (s_q.ctrl.mode == `ICC_MODE_EVERY) && run && (rise || fall) |=> capture_irq_o)
        else $error("both-edge mode missed a capture interrupt");

    a_fall_capture: assert property (
        (s_q.ctrl.mode == `ICC_MODE_FALL) && run |-> (cap == fall))
        else $error("falling-edge mode capture mismatch");

    a_rise_capture: assert property (
        (s_q.ctrl.mode == `ICC_MODE_RISE) && run |-> (cap == rise))
        else $error("rising-edge mode capture mismatch");

    a_pre4_count: assert property (
        (s_q.ctrl.mode == `ICC_MODE_PRE4) && cap |-> (s_q.pre_cnt == 4'h3) ##1 (s_q.pre_cnt == 4'h0))
        else $error("four-edge prescale fired on wrong edge");

    a_pre16_count: assert property (
        (s_q.ctrl.mode == `ICC_MODE_PRE16) && cap |-> rise && (s_q.pre_cnt == 4'hf))
        else $error("sixteen-edge prescale fired on wrong edge");

    a_unused_mode: assert property (
        (s_q.ctrl.mode == `ICC_MODE_UNUSED) |-> !cap ##1 (buf_count == '0))
        else $error("unused mode captured or held data");

    a_wake_pulse: assert property (
        (s_q.ctrl.mode == `ICC_MODE_WAKE) && rise && (cpu_sleep_i || cpu_idle_i)
        |-> !cap ##1 wake_irq_o)
        else $error("wake pin edge did not raise wake pulse");

    a_timer_select: assert property (
        cap && buf_empty |=> (buf_head == ($past(s_q.ctrl.tmr) ? $past(second_timer_count_i)
                                                               : $past(third_timer_count_i))))
        else $error("wrong timer captured");

    a_pace_quiet: assert property (
        cap && (s_q.ctrl.mode != `ICC_MODE_EVERY) && (s_q.ctrl.ici != 2'h0)
        && (s_q.irq_cnt != s_q.ctrl.ici) |=> !capture_irq_o)
        else $error("capture interrupt before the paced count");

    a_ovf_set: assert property (
        cap && buf_full && !pop && capturing(s_q.ctrl.mode) |=> s_q.ovf [*1] ##0 buf_full)
        else $error("overflow not flagged on full buffer");

    a_bne_status: assert property (
        s_q.ack && !$past(wb_req_i.we) && ($past(wb_req_i.adr) == `ICC_CTRL_OFS)
        |-> (s_q.rdat[`ICC_BNE_BIT] == $past(!buf_empty)))
        else $error("buffer status readback wrong");

    a_idle_halt: assert property (
        cpu_idle_i && s_q.ctrl.sidl |-> !cap)
        else $error("capture while halted in idle");

    a_zero_bits: assert property (
        s_q.ack && ($past(wb_req_i.adr) != `ICC_BUF_OFS)
        |-> (s_q.rdat[15:14] == 2'h0) && (s_q.rdat[12:8] == 5'h00))
        else $error("unimplemented control bits read nonzero");

    a_ovf_off_clear: assert property (
        !capturing(s_q.ctrl.mode) |=> !s_q.ovf && (buf_count == '0))
        else $error("flags not cleared when switched off");

    a_pace_fire: assert property (
        cap && (s_q.ctrl.mode != `ICC_MODE_EVERY) && (s_q.irq_cnt == s_q.ctrl.ici)
        |=> capture_irq_o)
        else $error("paced capture interrupt missing");

    a_sleep_halt: assert property (
        cpu_sleep_i |-> !cap)
        else $error("capture while asleep");

    a_ovf_read_clear: assert property (
        pop && (buf_count == `ICC_FIFO_CW'(1)) && !cap |=> !s_q.ovf && buf_empty)
        else $error("flags not cleared when buffer read empty");

    a_wake_quiet: assert property (
        !cpu_sleep_i && !cpu_idle_i |=> !wake_irq_o)
        else $error("wake pulse while running");

    c_overflow:   cover property (cap && buf_full && !pop);
    c_pre16:      cover property ((s_q.ctrl.mode == `ICC_MODE_PRE16) && cap);
    c_paced_irq:  cover property ((s_q.ctrl.ici == 2'h3) && s_d.irq);
    c_wake:       cover property (wake_irq_o);
    c_buf_read:   cover property (pop ##1 s_q.ack);

endmodule // icc_top

`default_nettype wire

// *** core/icc_cfg.svh ***
/*
 * Constants of the input capture channel: register offsets, field positions,
 * reset values, mode codes and prescale counts.
 * Assumes it is included by its bare name from the package and the design files.
 */
`ifndef ICC_CFG_SVH
`define ICC_CFG_SVH

// ==========================================================================
// bus and storage sizes
`define ICC_ADDR_W       8
`define ICC_DATA_W       16
`define ICC_FIFO_DEPTH   4
`define ICC_FIFO_AW      2
`define ICC_FIFO_CW      3

// ==========================================================================
// register byte offsets (word aligned)
`define ICC_CTRL_OFS     8'h00
`define ICC_BUF_OFS      8'h04

// ==========================================================================
// control register field positions and reset value
`define ICC_SIDL_BIT     13
`define ICC_TMR_BIT      7
`define ICC_ICI_LSB      5
`define ICC_OVF_BIT      4
`define ICC_BNE_BIT      3
`define ICC_MODE_LSB     0
`define ICC_CTRL_RST     16'h0000

// ==========================================================================
// mode codes
`define ICC_MODE_OFF     3'h0
`define ICC_MODE_EVERY   3'h1
`define ICC_MODE_FALL    3'h2
`define ICC_MODE_RISE    3'h3
`define ICC_MODE_PRE4    3'h4
`define ICC_MODE_PRE16   3'h5
`define ICC_MODE_UNUSED  3'h6
`define ICC_MODE_WAKE    3'h7

// ==========================================================================
// prescaler terminal counts (edges counted from zero)
`define ICC_PRE4_LAST    4'h3
`define ICC_PRE16_LAST   4'hf

`endif

// *** core/icc_pkg.sv ***
/*
 * Types of the input capture channel: bus carriers, control fields and the
 * packed state of each module.
 * Assumes icc_cfg.svh is on the include path.
 */
`default_nettype none

`include "icc_cfg.svh"

package icc_pkg;

    // ======================================================================
    // plain words
    typedef logic [`ICC_DATA_W-1:0] icc_word_t;

    // ======================================================================
    // wishbone carriers
    typedef struct packed {
        logic                   cyc;
        logic                   stb;
        logic                   we;
        logic [`ICC_ADDR_W-1:0] adr;
        logic [3:0]             sel;
        logic [31:0]            dat;
    } icc_wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } icc_wb_rsp_s;

    // ======================================================================
    // control fields that software writes
    typedef struct packed {
        logic       sidl;
        logic       tmr;
        logic [1:0] ici;
        logic [2:0] mode;
    } icc_ctrl_s;

    // ======================================================================
    // module states
    typedef struct packed {
        icc_word_t [`ICC_FIFO_DEPTH-1:0] mem;
        logic [`ICC_FIFO_AW-1:0]         wr_ptr;
        logic [`ICC_FIFO_AW-1:0]         rd_ptr;
        logic [`ICC_FIFO_CW-1:0]         count;
    } icc_fifo_s;

    typedef struct packed {
        icc_ctrl_s   ctrl;
        logic        pin_prev;
        logic [3:0]  pre_cnt;
        logic [1:0]  irq_cnt;
        logic        ovf;
        logic        ack;
        logic [31:0] rdat;
        logic        irq;
        logic        wake;
    } icc_state_s;

endpackage

`default_nettype wire

// *** core/icc_fifo.sv ***
/*
 * Capture buffer: a small first-in first-out store of timer values.
 * Assumes the caller pops only when not empty; a push that finds the
 * store full with no pop in the same cycle is dropped.
 */
`default_nettype none

`include "icc_cfg.svh"

module icc_fifo
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // control
    input  wire logic              clear_i,
    // write side
    input  wire logic              push_i,
    input  wire icc_pkg::icc_word_t push_data_i,
    // read side
    input  wire logic              pop_i,
    output logic [`ICC_DATA_W-1:0] head_o,
    // status
    output logic                   full_o,
    output logic                   empty_o,
    output logic [`ICC_FIFO_CW-1:0] count_o
);

    icc_pkg::icc_fifo_s f_q;
    icc_pkg::icc_fifo_s f_d;
    logic               do_push;
    logic               do_pop;

    // ======================================================================
    // status
    assign full_o  = (f_q.count == `ICC_FIFO_CW'(`ICC_FIFO_DEPTH));
    assign empty_o = (f_q.count == '0);
    assign count_o = f_q.count;
    assign head_o  = f_q.mem[f_q.rd_ptr];

    // ======================================================================
    // next state
    always_comb
    begin
        f_d     = f_q;
        do_pop  = pop_i && !empty_o;
        // a full store still takes a value when the oldest leaves together
        do_push = push_i && (!full_o || do_pop);
        if (do_push)
        begin
            f_d.mem[f_q.wr_ptr] = push_data_i;
            f_d.wr_ptr          = f_q.wr_ptr + 1'b1;
        end
        if (do_pop)
        begin
            f_d.rd_ptr = f_q.rd_ptr + 1'b1;
        end
        f_d.count = f_q.count + `ICC_FIFO_CW'(do_push) - `ICC_FIFO_CW'(do_pop);
        if (clear_i)
        begin
            f_d.wr_ptr = '0;
            f_d.rd_ptr = '0;
            f_d.count  = '0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            f_q <= '0;
        end
        else
        begin
            f_q <= f_d;
        end
    end

    // ======================================================================
    // checks
    a_fifo_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        f_q.count <= `ICC_FIFO_CW'(`ICC_FIFO_DEPTH))
        else $error("capture buffer count above depth");

endmodule // icc_fifo

`default_nettype wire

// *** sim/icc_pin_src.sv ***
/*
 * Pin source: the outside signal on the capture input. It toggles the pin
 * a set number of times with a fixed gap of idle cycles between toggles.
 * Assumes one clock shared with the channel and a synchronous reset.
 */
`default_nettype none

module icc_pin_src
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // burst request
    input  wire logic       start_i,
    input  wire logic [7:0] count_i,
    input  wire logic [1:0] gap_i,
    // pin and status
    output logic            pin_o,
    output logic            busy_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] left_q;
    logic [1:0] wait_q;

    // ======================================================================
    // burst engine
    // push-pull level; a gap of zero gives an edge every cycle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_o  <= 1'b0;
            left_q <= 8'h00;
            wait_q <= 2'h0;
        end
        else if (start_i && left_q == 8'h00)
        begin
            left_q <= count_i;
            wait_q <= gap_i;
        end
        else if (left_q != 8'h00)
        begin
            if (wait_q != 2'h0)
                wait_q <= wait_q - 2'h1;
            else
            begin
                pin_o  <= ~pin_o;
                left_q <= left_q - 8'h01;
                wait_q <= gap_i;
            end
        end
    end

    assign busy_o = left_q != 8'h00;
endmodule // icc_pin_src

`default_nettype wire

// *** sim/icc_top_test.sv ***
/*
 * Self-checking bench of the capture channel: wishbone tasks, a pin source,
 * a lockstep edge monitor and an integer model of buffer and pacing.
 * Assumes icc_pkg, icc_top and icc_pin_src are compiled first.
 */
`default_nettype none

module icc_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 clk_i;
    logic                 rst_i;
    logic                 idle;
    logic                 sleep;
    logic                 start;
    logic                 busy;
    logic                 pin;
    logic                 prev;
    logic                 arm;
    logic                 irq;
    logic                 wake;
    logic [7:0]           ntog;
    logic [1:0]           gap;
    logic [31:0]          d;
    icc_pkg::icc_word_t   t2;
    icc_pkg::icc_word_t   t3;
    icc_pkg::icc_wb_req_s req;
    icc_pkg::icc_wb_rsp_s rsp;
    logic [32:0]          edges[$];
    int                   n_errors;
    int                   n_checks;
    int                   n_irq;
    int                   n_wake;

    icc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .cap_pin_i(pin), .second_timer_count_i(t2), .third_timer_count_i(t3),
        .cpu_idle_i(idle), .cpu_sleep_i(sleep), .capture_irq_o(irq), .wake_irq_o(wake));
    icc_pin_src src (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .count_i(ntog),
        .gap_i(gap), .pin_o(pin), .busy_o(busy));

    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // ======================================================================
    // monitor: sees the same pre-edge values the channel samples
    always @(posedge clk_i)
    begin
        t2   <= 16'($urandom);
        t3   <= 16'($urandom);
        prev <= pin;
        if (irq === 1'b1) n_irq++;
        if (wake === 1'b1) n_wake++;
        if (arm && pin !== prev) edges.push_back({pin, t2, t3});
    end

    // ======================================================================
    // checking and closing
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ======================================================================
    // bus and pin tasks
    task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] wd,
                      output logic [31:0] q);
        int i;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h3, dat: {16'h0000, wd}};
        i = 0;
        do
        begin
            @(posedge clk_i);
            i++;
        end
        while (rsp.ack !== 1'b1 && i < 16);
        q = rsp.dat;
        req <= '0;
        if (i >= 16)
        begin
            n_errors++;
            conclude();
        end
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 16'h0000, q);
        chk(name, q, exp);
    endtask

    task automatic burst(input logic [7:0] n, input logic [1:0] g);
        int i;
        @(posedge clk_i);
        ntog  <= n;
        gap   <= g;
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        i = 0;
        do
        begin
            @(posedge clk_i);
            i++;
        end
        while (busy === 1'b1 && i < 1000);
        if (i >= 1000)
        begin
            n_errors++;
            conclude();
        end
        // captures and pulses land one cycle after the last edge
        repeat (4) @(posedge clk_i);
    endtask

    // ======================================================================
    // one configured burst, predicted by the model and compared
    task automatic run(input logic [2:0] mode, input logic [1:0] ici, input logic tmr,
                       input logic sidl, input logic id, input logic sl,
                       input logic [7:0] n, input logic [1:0] g, input logic drain);
        logic [15:0] q[$];
        logic [15:0] ctl;
        logic [31:0] x;
        logic        ovf;
        logic        r;
        logic        hit;
        int          pre;
        int          caps;
        int          wk;
        int          ib;
        int          wb0;
        pre  = 0;
        caps = 0;
        wk   = 0;
        ovf  = 1'b0;
        idle  <= id;
        sleep <= sl;
        ctl = {2'b00, sidl, 5'h00, tmr, ici, 2'b00, mode};
        wb(1'b1, 8'h00, ctl, x);
        ib  = n_irq;
        wb0 = n_wake;
        edges.delete();
        arm <= 1'b1;
        burst(n, g);
        arm <= 1'b0;
        foreach (edges[k])
        begin
            r   = edges[k][32];
            hit = 1'b0;
            wk += int'(mode == 3'h7 && (id || sl) && r);
            if (!(sl || (id && sidl)))
                case (mode)
                3'h1: hit = 1'b1;
                3'h2: hit = !r;
                3'h3: hit = r;
                3'h4, 3'h5:
                begin
                    pre += int'(r);
                    hit = r && (pre % (mode == 3'h4 ? 4 : 16) == 0);
                end
                default: hit = 1'b0;
                endcase
            if (hit)
            begin
                caps++;
                if (q.size() < 4)
                    q.push_back(tmr ? edges[k][31:16] : edges[k][15:0]);
                else
                    ovf = 1'b1;
            end
        end
        chk("irq count", 32'(n_irq - ib), 32'(mode == 3'h1 ? caps : caps / (ici + 1)));
        chk("wake count", 32'(n_wake - wb0), 32'(wk));
        rd_chk("status", 8'h00, {16'h0, ctl | {11'h0, ovf, q.size() != 0, 3'h0}});
        if (drain)
        begin
            while (q.size() != 0)
                rd_chk("buffer", 8'h04, {16'h0, q.pop_front()});
            rd_chk("drained", 8'h00, {16'h0, ctl});
        end
        else
        begin
            wb(1'b1, 8'h00, ctl & 16'hfff8, x);
            rd_chk("switched off", 8'h00, {16'h0, ctl & 16'hfff8});
        end
        rd_chk("empty read", 8'h04, 32'h0);
        $display("test mode %0d done", mode);
    endtask

    // ======================================================================
    // main sequence
    initial
    begin
        void'($urandom(35));
        rst_i = 1'b1;
        req   = '0;
        idle  = 1'b0;
        sleep = 1'b0;
        start = 1'b0;
        ntog  = 8'h00;
        gap   = 2'h0;
        arm   = 1'b0;
        prev  = 1'b0;
        t2    = 16'h0000;
        t3    = 16'h0000;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("reset control", 8'h00, 32'h0);
        wb(1'b1, 8'h08, 16'hffff, d);
        rd_chk("unmapped", 8'h08, 32'h0);
        wb(1'b1, 8'h00, 16'hffff, d);
        rd_chk("reserved bits", 8'h00, 32'h20e7);
        $display("test registers done");
        run(3'h0, 2'h0, 1'($urandom), 1'b0, 1'b0, 1'b0, 8'd6, 2'h1, 1'b1);
        run(3'h1, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 8'd4, 2'h0, 1'b1);
        run(3'h2, 2'h0, 1'($urandom), 1'b0, 1'b0, 1'b0, 8'd6, 2'h2, 1'b1);
        run(3'h3, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 8'd8, 2'h0, 1'b1);
        run(3'h4, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 8'd24, 2'h0, 1'b1);
        run(3'h5, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 8'd64, 2'h0, 1'b1);
        run(3'h6, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'd6, 2'h0, 1'b1);
        run(3'h7, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 8'd6, 2'h1, 1'b1);
        run(3'h7, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 8'd4, 2'h0, 1'b1);
        run(3'h7, 2'h0, 1'b0, 1'b1, 1'b1, 1'b0, 8'd4, 2'h0, 1'b1);
        run(3'h3, 2'h0, 1'b0, 1'b1, 1'b1, 1'b0, 8'd4, 2'h1, 1'b1);
        run(3'h3, 2'h3, 1'b0, 1'b0, 1'b1, 1'b0, 8'd8, 2'h0, 1'b1);
        run(3'h3, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1, 8'd4, 2'h0, 1'b1);
        run(3'h1, 2'h0, 1'($urandom), 1'b0, 1'b0, 1'b0, 8'd12, 2'h1, 1'b1);
        run(3'h1, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 8'd12, 2'h0, 1'b0);
        conclude();
    end
endmodule // icc_top_test

`default_nettype wire
